// file: mrm_ctrl.sv
// Purpose: operating mode latch, mode and relocation registers, map select
// Assumes: APB slave, zero wait states, inputs synchronous to ref_clk
// Notes: mode pins sampled at the first edge after reset release
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps

module mrm_ctrl
  import mrm_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Mode pins
  input wire logic background_pin,
  input wire logic mode_select_b,
  input wire logic mode_select_a,
  // CPU address decode
  input wire logic [15:0] cpu_addr,
  input wire logic eeprom_hit,
  input wire logic flash_hit,
  output logic sel_dbg_rom,
  output logic sel_dbg_ctl,
  output logic sel_regs,
  output logic sel_ram,
  output logic sel_eeprom,
  output logic sel_flash,
  output logic sel_ext,
  output logic port_e_regs_mapped,
  // Debug
  input wire logic dbg_serial_activate,
  input wire logic enter_debug_instruction,
  input wire logic dbg_exit,
  input wire logic dbg_req,
  input wire logic dbg_write,
  input wire logic dbg_nonvolatile,
  input wire logic cpu_bus_idle,
  output logic background_debug_mode,
  output logic dbg_grant,
  // Mode outputs
  input wire logic wait_mode,
  output logic cpu_inactive,
  output logic fetch_reset_vector,
  output logic ext_bus_enable,
  output logic port_e_bus_ctrl,
  output logic eclk_stretch,
  output logic internal_visible,
  output logic vis_wide,
  output logic ext_bus_shutdown,
  output logic map_if_shutdown,
  // External data beats
  input wire logic ext_req,
  input wire logic [15:0] ext_wdata,
  output logic ext_busy,
  output logic ext_wide_valid,
  output logic [15:0] ext_wide_data,
  output logic ext_byte_valid,
  output logic ext_byte_high,
  output logic [7:0] ext_byte_data
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic cap_done_q;
  logic special_mode_n_q;
  logic [1:0] mode_ba_q;
  logic eclk_stretch_enable_q, internal_visibility_q;
  logic ext_bus_wait_stop_q, port_e_emulate_q, mode_wr_seen_q;
  logic [4:0] register_block_position_bits_q, ram_position_bits_q;
  logic [4:0] reg_map_q, ram_map_q;
  logic map_if_wait_stop_q, reg_pos_seen_q, ram_pos_seen_q;
  logic dbg_enabled_q, dbg_active_q;
  logic [3:0] shut_cnt_q;
  mrm_split_t split_q;
  logic [7:0] lo_byte_q;
  logic [2:0] mode_code, pin_code;
  logic special, expanded, peripheral, narrow;
  logic apb_setup, apb_wr, addr_hit;
  logic [31:0] rd_word;
  logic d_dbg_rom, d_dbg_ctl, d_regs, d_ram, d_eep, d_flash, d_ext;

  // ----------------------------------------------------------------------
  // Mode decode
  // ----------------------------------------------------------------------
  always_comb begin
    pin_code = {background_pin, mode_select_b, mode_select_a};
    if (pin_code == MODE_RESERVED) begin
      pin_code = MODE_PERIPH;
    end
    mode_code = {special_mode_n_q, mode_ba_q};
    special = is_special(mode_code);
    expanded = is_expanded(mode_code);
    peripheral = mode_code == MODE_PERIPH;
    narrow = mode_ba_q == BA_NARROW;
  end

  // ----------------------------------------------------------------------
  // APB decode and read mux
  // ----------------------------------------------------------------------
  assign pready = 1'b1;
  assign apb_setup = psel && !penable;
  assign apb_wr = psel && penable && pwrite && pready && !pslverr;

  always_comb begin
    rd_word = '0;
    addr_hit = 1'b1;
    case (paddr)
      idx_to_adr(IDX_MODE): begin
        addr_hit = !peripheral;
        if (!peripheral) begin
          rd_word[MB_SPECIAL_MODE_N] = special_mode_n_q;
          rd_word[MB_MODE_SELECT_B] = mode_ba_q[1];
          rd_word[MB_MODE_SELECT_A] = mode_ba_q[0];
          rd_word[MB_ECLK_STRETCH_ENABLE] = eclk_stretch;
          rd_word[MB_INTERNAL_VISIBILITY] = internal_visibility_q;
          rd_word[MB_EXT_BUS_WAIT_STOP] = ext_bus_wait_stop_q;
          rd_word[MB_EME] = port_e_emulate_q;
        end
      end
      idx_to_adr(IDX_REG_POS): begin
        rd_word[POS_MSB:POS_LSB] = register_block_position_bits_q;
        rd_word[MAP_IF_WAIT_STOP_BIT] = map_if_wait_stop_q;
      end
      idx_to_adr(IDX_RAM_POS): begin
        rd_word[POS_MSB:POS_LSB] = ram_position_bits_q;
      end
      idx_to_adr(IDX_STATUS): begin
        rd_word[ST_DBG_ACTIVE] = dbg_active_q;
        rd_word[ST_DBG_ENABLED] = dbg_enabled_q;
        rd_word[ST_CPU_INACTIVE] = peripheral;
        rd_word[ST_EXT_SHUT] = ext_bus_shutdown;
        rd_word[ST_MODE_LSB +: 3] = mode_code;
      end
      idx_to_adr(IDX_DBG_CTL): begin
        rd_word[DC_ENABLE] = dbg_enabled_q;
      end
      default: begin
        addr_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (apb_setup) begin
      prdata <= pwrite ? '0 : rd_word;
      pslverr <= !addr_hit;
    end
  end

  // ----------------------------------------------------------------------
  // Mode register
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cap_done_q <= 1'b0;
      special_mode_n_q <= MODE_NSC[2];
      mode_ba_q <= MODE_NSC[1:0];
      eclk_stretch_enable_q <= 1'b1;
      internal_visibility_q <= 1'b0;
      ext_bus_wait_stop_q <= 1'b0;
      port_e_emulate_q <= 1'b0;
      mode_wr_seen_q <= 1'b0;
    end else if (!cap_done_q) begin
      cap_done_q <= 1'b1;
      special_mode_n_q <= pin_code[2];
      mode_ba_q <= pin_code[1:0];
      internal_visibility_q <= is_special(pin_code);
      port_e_emulate_q <= is_special(pin_code);
    end else if (apb_wr && paddr == idx_to_adr(IDX_MODE)) begin
      mode_wr_seen_q <= 1'b1;
      if (!special_mode_n_q && mode_wr_seen_q) begin
        special_mode_n_q <= pwdata[MB_SPECIAL_MODE_N];
      end
      if ((special || !mode_wr_seen_q) &&
          pwdata[MB_MODE_SELECT_B:MB_MODE_SELECT_A] != BA_PERIPH) begin
        mode_ba_q <= pwdata[MB_MODE_SELECT_B:MB_MODE_SELECT_A];
      end
      if (special || !mode_wr_seen_q) begin
        eclk_stretch_enable_q <= pwdata[MB_ECLK_STRETCH_ENABLE];
      end
      if (special ? mode_wr_seen_q : !mode_wr_seen_q) begin
        internal_visibility_q <= pwdata[MB_INTERNAL_VISIBILITY];
        port_e_emulate_q <= pwdata[MB_EME];
      end
      if (!special) begin
        ext_bus_wait_stop_q <= pwdata[MB_EXT_BUS_WAIT_STOP];
      end
    end
  end

  // ----------------------------------------------------------------------
  // Relocation registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      register_block_position_bits_q <= REG_POS_RST;
      map_if_wait_stop_q <= 1'b0;
      reg_pos_seen_q <= 1'b0;
    end else if (apb_wr && paddr == idx_to_adr(IDX_REG_POS)) begin
      reg_pos_seen_q <= 1'b1;
      if (special || !reg_pos_seen_q) begin
        register_block_position_bits_q <= pwdata[POS_MSB:POS_LSB];
      end
      if (!special) begin
        map_if_wait_stop_q <= pwdata[MAP_IF_WAIT_STOP_BIT];
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ram_position_bits_q <= RAM_POS_RST;
      ram_pos_seen_q <= 1'b0;
    end else if (apb_wr && paddr == idx_to_adr(IDX_RAM_POS)) begin
      ram_pos_seen_q <= 1'b1;
      if (special || !ram_pos_seen_q) begin
        ram_position_bits_q <= pwdata[POS_MSB:POS_LSB];
      end
    end
  end

  // Map copy lags the register by one cycle
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      reg_map_q <= REG_POS_RST;
      ram_map_q <= RAM_POS_RST;
    end else begin
      reg_map_q <= register_block_position_bits_q;
      ram_map_q <= ram_position_bits_q;
    end
  end

  // ----------------------------------------------------------------------
  // Debug mode
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      dbg_enabled_q <= 1'b0;
      dbg_active_q <= 1'b0;
    end else if (!cap_done_q) begin
      dbg_enabled_q <= pin_code == MODE_SSC;
      dbg_active_q <= pin_code == MODE_SSC;
    end else if (peripheral) begin
      dbg_enabled_q <= 1'b0;
      dbg_active_q <= 1'b0;
    end else begin
      if (apb_wr && paddr == idx_to_adr(IDX_DBG_CTL)) begin
        dbg_enabled_q <= pwdata[DC_ENABLE];
      end
      if (dbg_exit) begin
        dbg_active_q <= 1'b0;
      end else if (dbg_enabled_q &&
                   (dbg_serial_activate || enter_debug_instruction)) begin
        dbg_active_q <= 1'b1;
      end
    end
  end

  assign dbg_grant = dbg_req && cpu_bus_idle && dbg_enabled_q &&
                     !(dbg_write && dbg_nonvolatile);

  // ----------------------------------------------------------------------
  // Address select
  // ----------------------------------------------------------------------
  mrm_decode u_decode (
    .addr(cpu_addr),
    .dbg_active(dbg_active_q),
    .expanded(expanded),
    .reg_pos(reg_map_q),
    .ram_pos(ram_map_q),
    .eeprom_hit(eeprom_hit),
    .flash_hit(flash_hit),
    .sel_dbg_rom(d_dbg_rom),
    .sel_dbg_ctl(d_dbg_ctl),
    .sel_regs(d_regs),
    .sel_ram(d_ram),
    .sel_eeprom(d_eep),
    .sel_flash(d_flash),
    .sel_ext(d_ext)
  );

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      {sel_dbg_rom, sel_dbg_ctl, sel_regs, sel_ram} <= '0;
      {sel_eeprom, sel_flash, sel_ext} <= '0;
    end else begin
      {sel_dbg_rom, sel_dbg_ctl, sel_regs, sel_ram} <=
        {d_dbg_rom, d_dbg_ctl, d_regs, d_ram};
      {sel_eeprom, sel_flash, sel_ext} <= {d_eep, d_flash, d_ext};
    end
  end

  // ----------------------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cpu_inactive <= 1'b1;
      fetch_reset_vector <= 1'b0;
      ext_bus_enable <= 1'b0;
      port_e_bus_ctrl <= 1'b0;
      port_e_regs_mapped <= 1'b1;
      internal_visible <= 1'b0;
      vis_wide <= 1'b0;
      map_if_shutdown <= 1'b0;
    end else begin
      cpu_inactive <= !cap_done_q || peripheral;
      fetch_reset_vector <= cap_done_q && !peripheral &&
                            mode_code != MODE_SSC;
      ext_bus_enable <= cap_done_q && expanded;
      port_e_bus_ctrl <= cap_done_q && expanded;
      port_e_regs_mapped <= !(expanded && port_e_emulate_q);
      internal_visible <= expanded && internal_visibility_q &&
                          !(!special && narrow);
      vis_wide <= special && narrow && internal_visibility_q;
      map_if_shutdown <= wait_mode && map_if_wait_stop_q;
    end
  end

  assign eclk_stretch = eclk_stretch_enable_q || expanded;
  assign background_debug_mode = dbg_active_q;

  // External bus stop in wait, after a settle delay
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      shut_cnt_q <= '0;
      ext_bus_shutdown <= 1'b0;
    end else if (wait_mode && ext_bus_wait_stop_q && expanded) begin
      if (shut_cnt_q == 4'(EXT_SHUT_CYC)) begin
        ext_bus_shutdown <= 1'b1;
      end else begin
        shut_cnt_q <= shut_cnt_q + 4'h1;
      end
    end else begin
      shut_cnt_q <= '0;
      ext_bus_shutdown <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // External data beats
  // ----------------------------------------------------------------------
  assign ext_busy = split_q != SPL_IDLE;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      split_q <= SPL_IDLE;
      lo_byte_q <= '0;
      ext_wide_valid <= 1'b0;
      ext_wide_data <= '0;
      ext_byte_valid <= 1'b0;
      ext_byte_high <= 1'b0;
      ext_byte_data <= '0;
    end else begin
      ext_wide_valid <= 1'b0;
      case (split_q)
        SPL_IDLE: begin
          ext_byte_valid <= 1'b0;
          if (ext_req && expanded && narrow) begin
            split_q <= SPL_HI;
            ext_byte_valid <= 1'b1;
            ext_byte_high <= 1'b1;
            ext_byte_data <= ext_wdata[15:8];
            lo_byte_q <= ext_wdata[7:0];
          end else if (ext_req && expanded) begin
            ext_wide_valid <= 1'b1;
            ext_wide_data <= ext_wdata;
          end
        end
        SPL_HI: begin
          split_q <= SPL_LO;
          ext_byte_high <= 1'b0;
          ext_byte_data <= lo_byte_q;
        end
        SPL_LO: begin
          split_q <= SPL_IDLE;
          ext_byte_valid <= 1'b0;
        end
        default: begin
          split_q <= SPL_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_narrow_req;
    ext_req && !ext_busy && expanded && narrow;
  endsequence
  sequence s_two_beats;
    (ext_byte_valid && ext_byte_high) ##1
    (ext_byte_valid && !ext_byte_high) ##1 !ext_byte_valid;
  endsequence

  AST_SPLIT: assert property (s_narrow_req |=> s_two_beats)
    else $error("narrow transfer not split high then low");
  AST_RESVEC: assert property (
    cap_done_q && mode_code == MODE_SSC |=> !fetch_reset_vector)
    else $error("reset vector fetched in special single chip");
  AST_PERIPH_CPU: assert property (
    peripheral |=> cpu_inactive && !dbg_active_q)
    else $error("cpu or debug active in peripheral mode");
  AST_DBG_SSC: assert property (
    !cap_done_q && pin_code == MODE_SSC |=> dbg_active_q)
    else $error("debug not active after special single chip reset");
  AST_MAP_DELAY: assert property (
    $changed(register_block_position_bits_q) |->
    reg_map_q == $past(register_block_position_bits_q) ##1
    reg_map_q == register_block_position_bits_q)
    else $error("register block map not one cycle late");
  AST_ONEHOT: assert property (
    $onehot0({sel_dbg_rom, sel_regs, sel_ram, sel_eeprom,
              sel_flash, sel_ext}))
    else $error("more than one resource selected");
  AST_MODE_UNMAP: assert property (
    apb_setup && peripheral && paddr == idx_to_adr(IDX_MODE)
    |=> pslverr && prdata == '0)
    else $error("mode register visible in peripheral mode");
  AST_NO_PERIPH: assert property (
    cap_done_q && $past(cap_done_q) && $changed(mode_ba_q)
    |-> mode_ba_q != BA_PERIPH)
    else $error("peripheral encoding selected by write");
  AST_ECLK_STRETCH_ENABLE: assert property (expanded |-> eclk_stretch)
    else $error("clock stretch not forced in expanded mode");
  AST_SHUT: assert property (
    $rose(ext_bus_shutdown) |->
    $past(wait_mode, 5) && $past(ext_bus_wait_stop_q, 5))
    else $error("external bus stopped without full delay");

endmodule // mrm_ctrl

// file: mrm_ctrl_tb.sv
// Purpose: self-checking bench for the mode and resource map block
// Assumes: zero wait APB, registers at four times their index
// Notes: four resets cover normal, debug, peripheral and reserved pin modes
`timescale 1ns/10ps
`define CHK(n,e,g) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", n, e, g); end end
module mrm_ctrl_tb;
  import mrm_pkg::*;
  logic ref_clk=0, reset=1, psel=0, penable=0, pwrite=0, pready, pslverr;
  logic [7:0] paddr=8'h00;
  logic [31:0] pwdata=32'h0, prdata, rd;
  logic background_pin=1, mode_select_b=0, mode_select_a=1, er;
  logic [15:0] cpu_addr=16'h0000, ext_wdata=16'h0000, ext_wide_data;
  logic eeprom_hit=0, flash_hit=0, dbg_serial_activate=0, dbg_exit=0;
  logic enter_debug_instruction=0, dbg_req=0, dbg_write=0, ext_req=0;
  logic dbg_nonvolatile=0, cpu_bus_idle=0, wait_mode=0;
  logic sel_dbg_rom, sel_dbg_ctl, sel_regs, sel_ram, sel_eeprom, sel_flash;
  logic sel_ext, port_e_regs_mapped, background_debug_mode, dbg_grant;
  logic cpu_inactive, fetch_reset_vector, ext_bus_enable, port_e_bus_ctrl;
  logic eclk_stretch, internal_visible, vis_wide, ext_bus_shutdown;
  logic map_if_shutdown, ext_busy, ext_wide_valid, ext_byte_valid;
  logic ext_byte_high;
  logic [7:0] ext_byte_data;
  int checked=0, fail_count=0, cyc=0;
  mrm_ctrl dut_u (.*);
  mrm_ext_mem mem_u (.ref_clk(ref_clk), .byte_valid(ext_byte_valid),
    .byte_high(ext_byte_high), .byte_data(ext_byte_data),
    .wide_valid(ext_wide_valid), .wide_data(ext_wide_data));
  initial forever #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      end_of_test();
    end
  end
  task rst(input logic [2:0] pins);
    {background_pin, mode_select_b, mode_select_a} <= pins;
    reset <= 1;
    repeat (16) @(posedge ref_clk);
    reset <= 0;
    repeat (2) @(posedge ref_clk);
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task rreg(input logic [7:0] a, input logic [7:0] e, input string n);
    apb(0, a, 32'h0);
    `CHK(n, e, rd[7:0])
  endtask
  task dec(input logic [15:0] a, input logic [6:0] e, input string n);
    @(posedge ref_clk);
    cpu_addr <= a;
    repeat (2) @(posedge ref_clk);
    #1;
    `CHK(n, e, {sel_dbg_rom, sel_regs, sel_ram, sel_eeprom, sel_flash,
      sel_ext, sel_dbg_ctl})
    @(posedge ref_clk);
  endtask
  task t_norm;
    rst(3'h5);
    rreg(8'h2C, 8'hB0, "mode");
    rreg(8'h30, 8'h00, "regpos");
    rreg(8'h34, 8'h08, "rampos");
    apb(1, 8'h2C, 32'hC0);
    rreg(8'h2C, 8'hB0, "mode wr");
    apb(1, 8'h34, 32'h10);
    apb(1, 8'h34, 32'h18);
    rreg(8'h34, 8'h10, "ram once");
    dec(16'h1000, 7'h10, "ram moved");
    dec(16'h0800, 7'h02, "ext");
    eeprom_hit <= 1;
    dec(16'h0010, 7'h20, "regs first");
    eeprom_hit <= 0;
    `CHK("stretch", 1'b1, eclk_stretch)
    @(posedge ref_clk);
    ext_req <= 1;
    ext_wdata <= 16'hA55A;
    @(posedge ref_clk);
    ext_req <= 0;
    #1 `CHK("hi", 11'h7A5,
      {ext_busy, ext_byte_valid, ext_byte_high, ext_byte_data})
    @(posedge ref_clk);
    #1 `CHK("lo", 11'h65A,
      {ext_busy, ext_byte_valid, ext_byte_high, ext_byte_data})
    @(posedge ref_clk);
    #1 `CHK("word", 16'hA55A, mem_u.word_q)
    apb(1, 8'h2C, 32'h04);
    rreg(8'h2C, 8'hB4, "ext_bus_wait_stop");
    apb(1, 8'h30, 32'h01);
    wait_mode <= 1;
    repeat (5) @(posedge ref_clk);
    #1 `CHK("shut early", 1'b0, ext_bus_shutdown)
    @(posedge ref_clk);
    #1 `CHK("ext shut", 1'b1, ext_bus_shutdown)
    `CHK("map shut", 1'b1, map_if_shutdown)
    @(posedge ref_clk);
    wait_mode <= 0;
    dbg_serial_activate <= 1;
    @(posedge ref_clk);
    dbg_serial_activate <= 0;
    #1 `CHK("dbg off", 1'b0, background_debug_mode)
    apb(1, 8'h3C, 32'h01);
    enter_debug_instruction <= 1;
    @(posedge ref_clk);
    enter_debug_instruction <= 0;
    #1 `CHK("enter_debug_instruction", 1'b1, background_debug_mode)
    @(posedge ref_clk);
    dbg_exit <= 1;
    @(posedge ref_clk);
    dbg_exit <= 0;
    #1 `CHK("exit", 1'b0, background_debug_mode)
    @(posedge ref_clk);
    $display("test normal done");
  endtask
  task t_ssc;
    rst(3'h0);
    rreg(8'h2C, 8'h19, "mode");
    `CHK("dbg", 1'b1, background_debug_mode)
    `CHK("vector", 1'b0, fetch_reset_vector)
    `CHK("no ext bus", 1'b0, ext_bus_enable)
    `CHK("pe mapped", 1'b1, port_e_regs_mapped)
    dec(16'hFF03, 7'h41, "dbg ctl");
    dec(16'hFF10, 7'h40, "dbg rom");
    flash_hit <= 1;
    dec(16'h8000, 7'h04, "flash");
    flash_hit <= 0;
    dbg_req <= 1;
    cpu_bus_idle <= 1;
    @(posedge ref_clk);
    #1 `CHK("grant", 1'b1, dbg_grant)
    @(posedge ref_clk);
    dbg_write <= 1;
    dbg_nonvolatile <= 1;
    @(posedge ref_clk);
    #1 `CHK("no nv wr", 1'b0, dbg_grant)
    apb(1, 8'h30, 32'h08);
    apb(1, 8'h30, 32'h10);
    rreg(8'h30, 8'h10, "reg free");
    dbg_req <= 0;
    apb(1, 8'h2C, 32'h60);
    rreg(8'h2C, 8'h79, "mode wide");
    #1 `CHK("pe bus", 1'b1, port_e_bus_ctrl)
    `CHK("pe unmap", 1'b0, port_e_regs_mapped)
    `CHK("internal_visibility", 1'b1, internal_visible)
    @(posedge ref_clk);
    ext_req <= 1;
    ext_wdata <= 16'h1234;
    @(posedge ref_clk);
    ext_req <= 0;
    #1 `CHK("wide", 18'h11234,
      {ext_byte_valid, ext_wide_valid, ext_wide_data})
    @(posedge ref_clk);
    #1 `CHK("wide word", 16'h1234, mem_u.word_q)
    @(posedge ref_clk);
    $display("test special done");
  endtask
  task t_per;
    rst(3'h2);
    apb(0, 8'h2C, 32'h0);
    `CHK("unmapped", 1'b1, er)
    `CHK("cpu off", 1'b1, cpu_inactive)
    `CHK("no dbg", 1'b0, background_debug_mode)
    rst(3'h6);
    rreg(8'h38, 8'h24, "reserved");
    $display("test peripheral done");
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    t_norm();
    t_ssc();
    t_per();
    end_of_test();
  end
endmodule // mrm_ctrl_tb

// file: mrm_decode.sv
// Purpose: internal resource select by fixed precedence
// Assumes: position fields already delayed to their effective cycle
// Notes: purely combinational, at most one select high apart from sel_dbg_ctl, which rides with sel_dbg_rom
`timescale 1ns/10ps
module mrm_decode
  import mrm_pkg::*;
(
  // Address and map state
  input wire logic [15:0] addr,
  input wire logic dbg_active,
  input wire logic expanded,
  input wire logic [4:0] reg_pos,
  input wire logic [4:0] ram_pos,
  input wire logic eeprom_hit,
  input wire logic flash_hit,
  // Selects
  output logic sel_dbg_rom,
  output logic sel_dbg_ctl,
  output logic sel_regs,
  output logic sel_ram,
  output logic sel_eeprom,
  output logic sel_flash,
  output logic sel_ext
);

  logic hit_dbg, hit_regs, hit_ram;

  always_comb begin
    hit_dbg = dbg_active && (addr[15:8] == DBG_ROM_PAGE);
    hit_regs = pos_hit(addr, reg_pos) && (addr[10:9] == 2'h0);
    hit_ram = pos_hit(addr, ram_pos) && !addr[10];
    sel_dbg_rom = hit_dbg;
    sel_dbg_ctl = hit_dbg && (addr[7:0] <= DBG_CTL_LAST);
    sel_regs = !hit_dbg && hit_regs;
    sel_ram = !hit_dbg && !hit_regs && hit_ram;
    sel_eeprom = !hit_dbg && !hit_regs && !hit_ram && eeprom_hit;
    sel_flash = !hit_dbg && !hit_regs && !hit_ram && !eeprom_hit &&
                flash_hit;
    sel_ext = expanded && !hit_dbg && !hit_regs && !hit_ram &&
              !eeprom_hit && !flash_hit;
  end

endmodule // mrm_decode

// file: mrm_ext_mem.sv
// Purpose: far side model of the external memory bus
// Assumes: beats arrive as registered one-cycle pulses
// Notes: assembles the last word seen on the bus
`timescale 1ns/10ps
module mrm_ext_mem (
  // Clock
  input wire logic ref_clk,
  // Beats
  input wire logic byte_valid,
  input wire logic byte_high,
  input wire logic [7:0] byte_data,
  input wire logic wide_valid,
  input wire logic [15:0] wide_data
);
  logic [15:0] word_q;
  initial word_q = 16'h0000;
  always @(posedge ref_clk) begin
    if (wide_valid) word_q <= wide_data;
    if (byte_valid && byte_high) word_q[15:8] <= byte_data;
    if (byte_valid && !byte_high) word_q[7:0] <= byte_data;
  end
endmodule // mrm_ext_mem

// file: mrm_pkg.sv
// Purpose: constants and helpers for the mode and resource map block
// Assumes: APB word registers, 16-bit CPU address space
// Notes: register byte address is four times the register index
package mrm_pkg;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_MODE = 8'h0B;
  localparam logic [7:0] IDX_REG_POS = 8'h0C;
  localparam logic [7:0] IDX_RAM_POS = 8'h0D;
  localparam logic [7:0] IDX_STATUS = 8'h0E;
  localparam logic [7:0] IDX_DBG_CTL = 8'h0F;

  // ----------------------------------------------------------------------
  // Mode register fields
  // ----------------------------------------------------------------------
  localparam int MB_SPECIAL_MODE_N = 7;
  localparam int MB_MODE_SELECT_B = 6;
  localparam int MB_MODE_SELECT_A = 5;
  localparam int MB_ECLK_STRETCH_ENABLE = 4;
  localparam int MB_INTERNAL_VISIBILITY = 3;
  localparam int MB_EXT_BUS_WAIT_STOP = 2;
  localparam int MB_EME = 0;

  // ----------------------------------------------------------------------
  // Position register fields and resets
  // ----------------------------------------------------------------------
  localparam int POS_MSB = 7;
  localparam int POS_LSB = 3;
  localparam int MAP_IF_WAIT_STOP_BIT = 0;
  localparam logic [4:0] REG_POS_RST = 5'h00;
  localparam logic [4:0] RAM_POS_RST = 5'h01;

  // ----------------------------------------------------------------------
  // Status and debug control fields
  // ----------------------------------------------------------------------
  localparam int ST_DBG_ACTIVE = 0;
  localparam int ST_DBG_ENABLED = 1;
  localparam int ST_CPU_INACTIVE = 2;
  localparam int ST_EXT_SHUT = 3;
  localparam int ST_MODE_LSB = 4;
  localparam int DC_ENABLE = 0;

  // ----------------------------------------------------------------------
  // Mode codes {special_mode_n, mode_select_b, mode_select_a}
  // ----------------------------------------------------------------------
  localparam logic [2:0] MODE_SSC = 3'h0;
  localparam logic [2:0] MODE_PERIPH = 3'h2;
  localparam logic [2:0] MODE_RESERVED = 3'h6;
  localparam logic [2:0] MODE_NSC = 3'h4;
  localparam logic [1:0] BA_PERIPH = 2'h2;
  localparam logic [1:0] BA_NARROW = 2'h1;

  // ----------------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------------
  localparam logic [7:0] DBG_ROM_PAGE = 8'hFF;
  localparam logic [7:0] DBG_CTL_LAST = 8'h06;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int EXT_SHUT_DLY_NS = 200;
  localparam int EXT_SHUT_CYC =
    (EXT_SHUT_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {SPL_IDLE, SPL_HI, SPL_LO} mrm_split_t;

  function automatic logic [7:0] idx_to_adr(input logic [7:0] idx);
    return {idx[5:0], 2'h0};
  endfunction

  function automatic logic is_special(input logic [2:0] code);
    return ~code[2];
  endfunction

  function automatic logic is_expanded(input logic [2:0] code);
    return code[0];
  endfunction

  function automatic logic pos_hit(input logic [15:0] addr,
                                   input logic [4:0] pos);
    return addr[15:11] == pos;
  endfunction

endpackage
